// *** common/adc_conversion_control_regs.svh ***
`ifndef ADC_CONVERSION_CONTROL_REGS_SVH
`define ADC_CONVERSION_CONTROL_REGS_SVH

// register offsets on the plain register port
`define ADC_RESULT_HIGH_OFS     4'h0
`define ADC_RESULT_LOW_OFS      4'h1
`define ADC_MODE_OFS            4'h2
`define ADC_START_OFS           4'h3
`define ADC_CLOCK_STOP_ONE_OFS  4'h4
`define ADC_PORT_MODE_ONE_OFS   4'h5
`define ADC_EDGE_SELECT_OFS     4'h6
`define ADC_IRQ_REQUEST_TWO_OFS 4'h7
`define ADC_IRQ_ENABLE_TWO_OFS  4'h8

// field positions
`define ADC_MODE_SPEED_BIT      7
`define ADC_MODE_TRIG_EN_BIT    6
`define ADC_START_RUN_BIT       7
`define ADC_STANDBY_CTRL_BIT    4
`define ADC_PIN_FUNCTION_BIT    4
`define ADC_EDGE_SELECT_BIT     4
`define ADC_DONE_FLAG_BIT       0

// reset values
`define ADC_MODE_RESET          8'h30
`define ADC_START_RESET         8'h7F
`define ADC_CLOCK_STOP_RESET    8'hFF
`define ADC_MODE_RESERVED_MASK  8'h30
`define ADC_START_RESERVED_MASK 8'h7F

// conversion periods in system clock cycles
`define ADC_PERIOD_SLOW         6'd62
`define ADC_PERIOD_FAST         6'd31

`endif

// *** common/adc_conversion_control_pkg.sv ***
`default_nettype none

package adc_conversion_control_pkg;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_s;

    typedef struct packed {
        logic       sample;
        logic [3:0] channel;
    } analog_sel_s;

    typedef enum logic [1:0] {
        ST_IDLE    = 2'b01,
        ST_CONVERT = 2'b10
    } conv_state_e;

endpackage

`default_nettype wire

// *** rtl/adc_conversion_control.sv ***
// The address map and the address-and-strobe port are this design's own decisions.
`include "adc_conversion_control_regs.svh"
`default_nettype none

// Summary of operation
// - successive approximation yields 10-bit results
// - writing run flag one starts conversion
// - run flag high during conversion, self-clears
// - run flag fall at completion, not on a stop write, sets done request
// - interrupt only while done enable set
// - trigger needs pin function and enable
// - selected trigger edge sets run flag
// - reset mode/start; registers hold in standby
// - result registers survive reset
// - channel code 0101 selects input one
// - completion stores, clears flag, goes idle
// - speed bit: 62 or 31 cycles
// - channel decode; 11xx prohibited
// - writing zero stops conversion; read status
// - high eight bits, low two bits 7:6
module adc_conversion_control
    import adc_conversion_control_pkg::*;
(
    input  wire logic                                     sys_clk,
    input  wire logic                                     reset,
    input  wire adc_conversion_control_pkg::reg_req_s     reg_req,
    output logic [7:0]                                    reg_rdata,
    input  wire logic                                     ext_trigger_pin,
    input  wire logic                                     comparator_high,
    output adc_conversion_control_pkg::analog_sel_s       analog_sel,
    output logic [9:0]                                    dac_code,
    output logic                                          conv_done_irq,
    output logic                                          converter_active
);
    import adc_conversion_control_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic trig_meta;
    logic trig_sync;
    logic trig_prev;
    logic cmp_meta;
    logic cmp_sync;

    always_ff @(posedge sys_clk) begin
        trig_meta <= ext_trigger_pin;
        trig_sync <= trig_meta;
        trig_prev <= trig_sync;
        cmp_meta  <= comparator_high;
        cmp_sync  <= cmp_meta;
    end

    ////////////////////////////////////////////////////////////////////////
    // registers

    logic [7:0]  converter_mode_reg;
    logic        conversion_run_flag;
    logic [7:0]  clock_stop_reg_one;
    logic [7:0]  port_mode_reg_one;
    logic [7:0]  edge_select_reg;
    logic        conv_done_request_flag;
    logic        conv_done_irq_enable;
    logic [9:0]  result;
    logic [7:0]  next_converter_mode_reg;
    logic        next_conversion_run_flag;
    logic [7:0]  next_clock_stop_reg_one;
    logic [7:0]  next_port_mode_reg_one;
    logic [7:0]  next_edge_select_reg;
    logic        next_conv_done_request_flag;
    logic        next_conv_done_irq_enable;
    logic [9:0]  next_result;
    logic [7:0]  next_reg_rdata;

    conv_state_e state;
    conv_state_e next_state;
    logic [5:0]  cycle_count;
    logic [5:0]  next_cycle_count;
    logic [9:0]  sar;
    logic [9:0]  next_sar;
    logic [9:0]  trial_bit;
    logic [9:0]  next_trial_bit;

    logic        module_enabled;
    logic        trigger_armed;
    logic        trigger_edge;
    logic        wr_start;
    logic        start_event;
    logic        stop_event;
    logic        period_done;
    logic [5:0]  period;
    logic        step_tick;

    assign module_enabled = clock_stop_reg_one[`ADC_STANDBY_CTRL_BIT];
    assign trigger_armed  = port_mode_reg_one[`ADC_PIN_FUNCTION_BIT]
                          & converter_mode_reg[`ADC_MODE_TRIG_EN_BIT];
    assign trigger_edge   = edge_select_reg[`ADC_EDGE_SELECT_BIT] ? (trig_sync & ~trig_prev)
                                                                  : (~trig_sync & trig_prev);
    assign wr_start       = reg_req.wr && reg_req.addr == `ADC_START_OFS;
    // standby freezes the converter; its registers still hold their values
    assign start_event    = module_enabled && state == ST_IDLE
                          && ((wr_start && reg_req.wdata[`ADC_START_RUN_BIT])
                              || (trigger_armed && trigger_edge));
    assign stop_event     = wr_start && !reg_req.wdata[`ADC_START_RUN_BIT];
    assign period         = converter_mode_reg[`ADC_MODE_SPEED_BIT] ? `ADC_PERIOD_FAST
                                                                    : `ADC_PERIOD_SLOW;
    assign period_done    = state == ST_CONVERT && module_enabled
                          && cycle_count == period - 6'd1;
    // one decision every third cycle: the trial code is registered, and the answer needs two more
    // cycles to come back through the synchroniser, so ten bits fit even in the short period
    assign step_tick      = module_enabled && state == ST_CONVERT && trial_bit != 10'h000
                          && cycle_count % 6'd3 == 6'd2;

    ////////////////////////////////////////////////////////////////////////
    // next-state logic

    always_comb begin
        next_converter_mode_reg     = converter_mode_reg;
        next_conversion_run_flag    = conversion_run_flag;
        next_clock_stop_reg_one     = clock_stop_reg_one;
        next_port_mode_reg_one      = port_mode_reg_one;
        next_edge_select_reg        = edge_select_reg;
        next_conv_done_request_flag = conv_done_request_flag;
        next_conv_done_irq_enable   = conv_done_irq_enable;
        next_result                 = result;
        next_state                  = state;
        next_cycle_count            = cycle_count;
        next_sar                    = sar;
        next_trial_bit              = trial_bit;

        if (reg_req.wr) begin
            unique case (reg_req.addr)
                `ADC_MODE_OFS: begin
                    next_converter_mode_reg = reg_req.wdata | `ADC_MODE_RESERVED_MASK;
                end
                `ADC_CLOCK_STOP_ONE_OFS: begin
                    next_clock_stop_reg_one = reg_req.wdata;
                end
                `ADC_PORT_MODE_ONE_OFS: begin
                    next_port_mode_reg_one = reg_req.wdata;
                end
                `ADC_EDGE_SELECT_OFS: begin
                    next_edge_select_reg = reg_req.wdata;
                end
                `ADC_IRQ_REQUEST_TWO_OFS: begin
                    // software may only clear the flag
                    if (!reg_req.wdata[`ADC_DONE_FLAG_BIT]) begin
                        next_conv_done_request_flag = 1'b0;
                    end
                end
                `ADC_IRQ_ENABLE_TWO_OFS: begin
                    next_conv_done_irq_enable = reg_req.wdata[`ADC_DONE_FLAG_BIT];
                end
                default: begin
                end
            endcase
        end

        unique case (state)
            ST_IDLE: begin
                if (start_event) begin
                    next_conversion_run_flag = 1'b1;
                    next_state               = ST_CONVERT;
                    next_cycle_count         = 6'd0;
                    next_sar                 = 10'h000;
                    next_trial_bit           = 10'h200;
                end
            end
            ST_CONVERT: begin
                if (stop_event) begin
                    next_conversion_run_flag = 1'b0;
                    next_state               = ST_IDLE;
                end else if (period_done) begin
                    next_result                 = sar;
                    next_conversion_run_flag    = 1'b0;
                    next_conv_done_request_flag = 1'b1;
                    next_state                  = ST_IDLE;
                end else if (module_enabled) begin
                    next_cycle_count = cycle_count + 6'd1;
                    if (step_tick) begin
                        // keep the trial bit when the ladder sits below the input
                        if (cmp_sync) begin
                            next_sar = sar | trial_bit;
                        end
                        next_trial_bit = trial_bit >> 1;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            converter_mode_reg     <= `ADC_MODE_RESET;
            conversion_run_flag    <= 1'b0;
            clock_stop_reg_one     <= `ADC_CLOCK_STOP_RESET;
            port_mode_reg_one      <= 8'h00;
            edge_select_reg        <= 8'h00;
            conv_done_request_flag <= 1'b0;
            conv_done_irq_enable   <= 1'b0;
            state                  <= ST_IDLE;
            cycle_count            <= 6'd0;
            sar                    <= 10'h000;
            trial_bit              <= 10'h000;
        end else begin
            converter_mode_reg     <= next_converter_mode_reg;
            conversion_run_flag    <= next_conversion_run_flag;
            clock_stop_reg_one     <= next_clock_stop_reg_one;
            port_mode_reg_one      <= next_port_mode_reg_one;
            edge_select_reg        <= next_edge_select_reg;
            conv_done_request_flag <= next_conv_done_request_flag;
            conv_done_irq_enable   <= next_conv_done_irq_enable;
            state                  <= next_state;
            cycle_count            <= next_cycle_count;
            sar                    <= next_sar;
            trial_bit              <= next_trial_bit;
        end
    end

    // result survives reset; undefined only at power-up
    always_ff @(posedge sys_clk) begin
        result <= next_result;
    end

    ////////////////////////////////////////////////////////////////////////
    // read port and outputs

    always_comb begin
        next_reg_rdata = 8'h00;
        if (reg_req.rd) begin
            unique case (reg_req.addr)
                `ADC_RESULT_HIGH_OFS:     next_reg_rdata = result[9:2];
                `ADC_RESULT_LOW_OFS:      next_reg_rdata = {result[1:0], 6'h00};
                `ADC_MODE_OFS:            next_reg_rdata = converter_mode_reg;
                `ADC_START_OFS:           next_reg_rdata = {conversion_run_flag, 7'h7F};
                `ADC_CLOCK_STOP_ONE_OFS:  next_reg_rdata = clock_stop_reg_one;
                `ADC_PORT_MODE_ONE_OFS:   next_reg_rdata = port_mode_reg_one;
                `ADC_EDGE_SELECT_OFS:     next_reg_rdata = edge_select_reg;
                `ADC_IRQ_REQUEST_TWO_OFS: next_reg_rdata = {7'h00, conv_done_request_flag};
                `ADC_IRQ_ENABLE_TWO_OFS:  next_reg_rdata = {7'h00, conv_done_irq_enable};
                default:                  next_reg_rdata = 8'h00;
            endcase
        end
    end

    logic [7:0]  rdata_q;
    analog_sel_s sel_q;
    logic [9:0]  dac_q;
    logic        irq_q;
    logic        channel_legal;
    logic [3:0]  channel_code;

    assign channel_code  = converter_mode_reg[3:0];
    // 00xx and the prohibited 11xx route nothing; 0101 reaches input one
    assign channel_legal = channel_code[3] ^ channel_code[2];

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rdata_q <= 8'h00;
            sel_q   <= '0;
            dac_q   <= 10'h000;
            irq_q   <= 1'b0;
        end else begin
            rdata_q        <= next_reg_rdata;
            // sampling starts with the first trial code so the first decision sees a live answer
            sel_q.sample   <= next_state == ST_CONVERT && channel_legal;
            sel_q.channel  <= channel_legal ? {1'b0, channel_code[3], channel_code[1:0]} : 4'h0;
            dac_q          <= next_sar | next_trial_bit;
            irq_q          <= next_conv_done_request_flag & next_conv_done_irq_enable;
        end
    end

    assign reg_rdata        = rdata_q;
    assign analog_sel       = sel_q;
    assign dac_code         = dac_q;
    assign conv_done_irq    = irq_q;
    assign converter_active = conversion_run_flag;

endmodule

`default_nettype wire

// *** sim/adc_conversion_control_asserts.sv ***
`include "adc_conversion_control_regs.svh"
`default_nettype none
module adc_conversion_control_asserts
    import adc_conversion_control_pkg::*;
(
    input wire logic                                        sys_clk,
    input wire logic                                        reset,
    input wire adc_conversion_control_pkg::reg_req_s        reg_req,
    input wire logic [7:0]                                  reg_rdata,
    input wire logic                                        ext_trigger_pin,
    input wire adc_conversion_control_pkg::analog_sel_s     analog_sel,
    input wire logic                                        conv_done_irq,
    input wire logic                                        converter_active
);
    // shadow of the control bits, rebuilt from the writes seen on the port
    logic       fast, ext_trigger_enable, pin_fn, rising, irq_en, run_on, wr_go, wr_stop, legal;
    logic [3:0] chan;
    logic [7:0] cnt;
    assign wr_go   = reg_req.wr && reg_req.addr == `ADC_START_OFS && reg_req.wdata[7];
    assign wr_stop = reg_req.wr && reg_req.addr == `ADC_START_OFS && !reg_req.wdata[7];
    assign legal   = chan[3] ^ chan[2];
    always_ff @(posedge sys_clk) begin
        cnt <= converter_active ? cnt + 8'h01 : 8'h00;
        if (reset) begin
            {fast, ext_trigger_enable, chan, pin_fn, rising, irq_en, run_on} <= 10'h001;
        end else if (reg_req.wr) begin
            case (reg_req.addr)
                `ADC_MODE_OFS: {fast, ext_trigger_enable, chan} <= {reg_req.wdata[7:6], reg_req.wdata[3:0]};
                `ADC_CLOCK_STOP_ONE_OFS: run_on <= reg_req.wdata[4];
                `ADC_PORT_MODE_ONE_OFS: pin_fn <= reg_req.wdata[4];
                `ADC_EDGE_SELECT_OFS: rising <= reg_req.wdata[4];
                `ADC_IRQ_ENABLE_TWO_OFS: irq_en <= reg_req.wdata[0];
                default: ;
            endcase
        end
    end
    ////////////////////////////////
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    property p_rdata_idle; !$past(reg_req.rd) |-> reg_rdata == 8'h00; endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
    property p_start; wr_go && !converter_active && run_on |=> converter_active; endproperty
    a_start: assert property (p_start) else $error("start write ignored");
    property p_stop; wr_stop && converter_active |=> !converter_active; endproperty
    a_stop: assert property (p_stop) else $error("stop write ignored");
    property p_period;
        $fell(converter_active) && !$past(wr_stop) |-> cnt == (fast ? 8'h1F : 8'h3E);
    endproperty
    a_period: assert property (p_period) else $error("conversion period wrong");
    property p_irq; $fell(converter_active) && !$past(wr_stop) && irq_en |-> ##[0:1] conv_done_irq; endproperty
    a_irq: assert property (p_irq) else $error("no end request");
    property p_irq_gate; !irq_en |-> !conv_done_irq; endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("request while disabled");
    property p_sample; analog_sel.sample |-> legal && analog_sel.channel == {1'b0, chan[3], chan[1:0]}; endproperty
    a_sample: assert property (p_sample) else $error("channel decode wrong");
    property p_sample_run; $rose(converter_active) && legal |-> ##[0:2] analog_sel.sample; endproperty
    a_sample_run: assert property (p_sample_run) else $error("no sampling in conversion");
    property p_trig;
        $rose(ext_trigger_pin) && rising && pin_fn && ext_trigger_enable && !converter_active |-> ##[2:6] converter_active;
    endproperty
    a_trig: assert property (p_trig) else $error("trigger edge did not start");
    property p_trig_off;
        $rose(ext_trigger_pin) && !(pin_fn && ext_trigger_enable) && !converter_active && !wr_go |=> !converter_active [*6];
    endproperty
    a_trig_off: assert property (p_trig_off) else $error("disabled trigger started");
    c_start: cover property (wr_go && run_on);
    c_end: cover property ($fell(converter_active) && !$past(wr_stop));
    c_trig: cover property ($rose(ext_trigger_pin) && pin_fn && ext_trigger_enable);
endmodule
bind adc_conversion_control adc_conversion_control_asserts i_chk (.sys_clk, .reset, .reg_req, .reg_rdata,
    .ext_trigger_pin, .analog_sel, .conv_done_irq, .converter_active);
`default_nettype wire

// *** sim/adc_analog_model.sv ***
`default_nettype none
module adc_analog_model
    import adc_conversion_control_pkg::*;
(
    input  wire logic                                     sys_clk,
    input  wire adc_conversion_control_pkg::analog_sel_s  analog_sel,
    input  wire logic [9:0]                               dac_code,
    input  wire logic [9:0]                               level,
    output logic                                          comparator_high
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       wobble;
    logic [9:0] vin;
    initial wobble = 1'b0;
    always @(posedge sys_clk) wobble <= ~wobble;
    // input one carries the level, all others its inverse, so a wrong route shows
    assign vin = (analog_sel.channel == 4'h1) ? level : ~level;
    // idle comparator toggles: a stale answer cannot pass for a real one
    assign comparator_high = analog_sel.sample ? (vin >= dac_code) : wobble;
endmodule
`default_nettype wire

// *** sim/tb.sv ***
`include "adc_conversion_control_regs.svh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import adc_conversion_control_pkg::*;
    localparam logic [9:0] L1 = 10'h2D6;
    localparam logic [9:0] L2 = 10'h0F3;
    logic        sys_clk, reset, ext_trigger_pin, comparator_high, conv_done_irq, converter_active;
    reg_req_s    reg_req;
    analog_sel_s analog_sel;
    logic [7:0]  reg_rdata;
    logic [9:0]  dac_code, level;
    int          fails, checked, n;
    adc_conversion_control i_dut (.sys_clk, .reset, .reg_req, .reg_rdata, .ext_trigger_pin,
        .comparator_high, .analog_sel, .dac_code, .conv_done_irq, .converter_active);
    adc_analog_model i_far (.sys_clk, .analog_sel, .dac_code, .level, .comparator_high);
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    ////////////////////////////////
    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        reg_req.wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        reg_req.rd <= 1'b0;
        #1 chk({2'b00, reg_rdata}, {2'b00, exp});
    endtask
    task automatic conv(input logic by_pin, input logic [7:0] exp_n);
        if (by_pin) begin
            @(posedge sys_clk);
            ext_trigger_pin <= 1'b1;
        end else begin
            wr(`ADC_START_OFS, 8'h80);
        end
        n = 0;
        repeat (200) begin
            #1;
            if (converter_active === 1'b1) n++;
            else if (n > 0) break;
            @(posedge sys_clk);
        end
        chk(n[9:0], {2'b00, exp_n});
    endtask
    task automatic print_verdict;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    ////////////////////////////////
    initial begin
        #100000;
        fails++;
        print_verdict();
    end
    initial begin
        reset = 1'b1;
        reg_req = '0;
        ext_trigger_pin = 1'b0;
        level = L1;
        fails = 0;
        checked = 0;
        repeat (8) @(posedge sys_clk);
        reset <= 1'b0;
        rd(`ADC_MODE_OFS, `ADC_MODE_RESET);
        rd(`ADC_START_OFS, `ADC_START_RESET);
        rd(`ADC_CLOCK_STOP_ONE_OFS, `ADC_CLOCK_STOP_RESET);
        rd(4'hF, 8'h00);
        wr(`ADC_IRQ_ENABLE_TWO_OFS, 8'h01);
        wr(`ADC_MODE_OFS, 8'h05);
        rd(`ADC_MODE_OFS, 8'h35);
        conv(1'b0, 8'h3E);
        rd(`ADC_START_OFS, 8'h7F);
        rd(`ADC_IRQ_REQUEST_TWO_OFS, 8'h01);
        chk(10'(conv_done_irq), 10'h001);
        rd(`ADC_RESULT_HIGH_OFS, L1[9:2]);
        rd(`ADC_RESULT_LOW_OFS, {L1[1:0], 6'h00});
        wr(`ADC_IRQ_REQUEST_TWO_OFS, 8'h00);
        repeat (2) @(posedge sys_clk);
        #1 chk(10'(conv_done_irq), 10'h000);
        wr(`ADC_IRQ_ENABLE_TWO_OFS, 8'h00);
        wr(`ADC_MODE_OFS, 8'h88);
        conv(1'b0, 8'h1F);
        rd(`ADC_RESULT_HIGH_OFS, ~L1[9:2]);
        chk(10'(conv_done_irq), 10'h000);
        level = L2;
        wr(`ADC_START_OFS, 8'h80);
        repeat (10) @(posedge sys_clk);
        wr(`ADC_START_OFS, 8'h00);
        rd(`ADC_START_OFS, 8'h7F);
        rd(`ADC_RESULT_HIGH_OFS, ~L1[9:2]);
        wr(`ADC_PORT_MODE_ONE_OFS, 8'h10);
        wr(`ADC_EDGE_SELECT_OFS, 8'h10);
        wr(`ADC_MODE_OFS, 8'h45);
        conv(1'b1, 8'h3E);
        rd(`ADC_RESULT_LOW_OFS, {L2[1:0], 6'h00});
        @(posedge sys_clk);
        ext_trigger_pin <= 1'b0;
        wr(`ADC_MODE_OFS, 8'h05);
        @(posedge sys_clk);
        ext_trigger_pin <= 1'b1;
        repeat (8) @(posedge sys_clk);
        #1 chk(10'(converter_active), 10'h000);
        wr(`ADC_CLOCK_STOP_ONE_OFS, 8'hEF);
        wr(`ADC_START_OFS, 8'h80);
        #1 chk(10'(converter_active), 10'h000);
        wr(`ADC_CLOCK_STOP_ONE_OFS, 8'hFF);
        repeat (10) @(posedge sys_clk);
        conv(1'b0, 8'h3E);
        @(posedge sys_clk);
        reset <= 1'b1;
        @(posedge sys_clk);
        reset <= 1'b0;
        rd(`ADC_RESULT_HIGH_OFS, L2[9:2]);
        rd(`ADC_MODE_OFS, `ADC_MODE_RESET);
        print_verdict();
    end
endmodule
`default_nettype wire
